// ===== src/svd_pkg.sv
// Constants for the supply voltage detect block
// Assumes a 250 MHz system clock and a word-wide AHB-Lite register bus
package svd_pkg;

   // Register byte offsets
   localparam logic [7:0] DETECT_OFFS     = 8'h0C;
   localparam logic [7:0] IRQ_STAT_OFFS   = 8'h10;
   localparam logic [7:0] IRQ_MASK_OFFS   = 8'h14;
   localparam logic [7:0] MON_STAT_OFFS   = 8'h18;

   // Field positions
   localparam int ENABLE_BIT   = 0;
   localparam int LOW_BIT      = 1;
   localparam int HIGH_BIT     = 2;
   localparam int ALARM_BIT    = 5;
   localparam int VALID_BIT    = 0;

   // Values after reset
   localparam logic       ENABLE_RST   = 1'b0;
   localparam logic       FLAG_RST     = 1'b0;
   localparam logic [7:0] IRQ_STAT_RST = 8'h00;
   localparam logic [7:0] IRQ_MASK_RST = 8'h00;

   // Settling time before flags are trusted
   localparam int SETTLE_TIME_US = 20;
   localparam int CLK_FREQ_MHZ   = 250;
   localparam int SETTLE_CYCLES  = SETTLE_TIME_US * CLK_FREQ_MHZ;

   // Synchroniser depth on comparator pins
   localparam int SYNC_STAGES = 2;

   // Monitor states, Gray along off, settling, active
   typedef enum logic [1:0]
   {
      MON_OFF    = 2'b00,
      MON_SETTLE = 2'b01,
      MON_ACTIVE = 2'b11
   } svd_mon_e;

endpackage

// ===== src/svd_sync.sv
// Two-flop synchroniser for asynchronous comparator levels
// Assumes sys_clk and synchronous active-high srst
`timescale 1ns/10ps
module svd_sync
#(
   parameter int W = 2
)
(
   input  wire logic     sys_clk,
   input  wire logic     srst,
   svd_sync_if.sync_side link
);

   logic [W-1:0] meta_q;
   logic [W-1:0] stable_q;

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         meta_q   <= '0;
         stable_q <= '0;
      end
      else
      begin
         meta_q   <= link.raw;
         stable_q <= meta_q;
      end
   end

   assign link.synced = stable_q;

endmodule

// ===== src/svd_sync_if.sv
// Carries raw comparator levels to the synchroniser and back
// Assumes both ends run on the same system clock
`timescale 1ns/10ps
interface svd_sync_if
#(
   parameter int W = 2
);
   logic [W-1:0] raw;
   logic [W-1:0] synced;

   modport sync_side
   (
      input  raw,
      output synced
   );

   modport user
   (
      output raw,
      input  synced
   );
endinterface

// ===== src/svd_top.sv
// Supply voltage detect: enable, level flags, alarm latch and interrupt
// Assumes async comparator levels and an AHB-Lite master on sys_clk
`timescale 1ns/10ps

module svd_top
#(
   parameter int SETTLE_CYCLES = svd_pkg::SETTLE_CYCLES
)
(
   input  wire logic        sys_clk,
   input  wire logic        srst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Analog comparators
   input  wire logic        aboveUpperThreshold,
   input  wire logic        belowLowerThreshold,
   output logic             supplyMonitorEnable,
   // Interrupt controller
   output logic             supplyAlarmRequest,
   output logic             irq
);

   localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
   localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Comparator synchronisation

   svd_sync_if #(.W(2)) cmpLink ();

   assign cmpLink.raw = {aboveUpperThreshold, belowLowerThreshold};

   svd_sync #(.W(2)) u_sync
   (
      .sys_clk (sys_clk),
      .srst    (srst),
      .link    (cmpLink.sync_side)
   );

   logic highSync;
   logic lowSync;

   assign highSync = cmpLink.synced[1];
   assign lowSync  = cmpLink.synced[0];

   ////////////////////////////////////////////////////////////////////////////
   // Register state

   logic                enable_q;
   logic                enable_d;
   logic                highFlag_q;
   logic                lowFlag_q;
   logic                alarmLatch_q;
   logic                alarmLatch_d;
   logic                alarmMask_q;
   logic                alarmMask_d;
   logic                alarmReq_q;
   logic                irq_q;
   svd_pkg::svd_mon_e   mon_q;
   svd_pkg::svd_mon_e   mon_d;
   logic [CNT_W-1:0]    settleCnt_q;
   logic [CNT_W-1:0]    settleCnt_d;

   ////////////////////////////////////////////////////////////////////////////
   // Bus address phase

   logic                wrPend_q;
   logic [7:0]          wrAddr_q;
   logic                rdStall_q;
   logic [7:0]          rdAddr_q;
   logic                hreadyout_q;
   logic [31:0]         hrdata_q;
   logic [31:0]         hrdata_d;

   logic                accept;
   logic                readAccept;
   logic                writeAccept;
   logic                readHazard;
   logic [7:0]          rdSelAddr;

   assign accept      = hsel && htrans[1] && hready;
   assign readAccept  = accept && !hwrite;
   assign writeAccept = accept && hwrite;
   assign readHazard  = readAccept && wrPend_q;
   assign rdSelAddr   = rdStall_q ? rdAddr_q : haddr[7:0];

   ////////////////////////////////////////////////////////////////////////////
   // Write decode, data phase

   logic wrDetect;
   logic wrIrqStat;
   logic wrIrqMask;

   assign wrDetect  = wrPend_q && (wrAddr_q == svd_pkg::DETECT_OFFS);
   assign wrIrqStat = wrPend_q && (wrAddr_q == svd_pkg::IRQ_STAT_OFFS);
   assign wrIrqMask = wrPend_q && (wrAddr_q == svd_pkg::IRQ_MASK_OFFS);

   ////////////////////////////////////////////////////////////////////////////
   // Read decode

   logic        rdDetect;
   logic        rdIrqStat;
   logic        rdIrqMask;
   logic        rdMonStat;
   logic [7:0]  detectView;
   logic [7:0]  irqStatView;
   logic [7:0]  irqMaskView;
   logic [7:0]  monStatView;
   logic [7:0]  readByte;

   assign rdDetect  = (rdSelAddr == svd_pkg::DETECT_OFFS);
   assign rdIrqStat = (rdSelAddr == svd_pkg::IRQ_STAT_OFFS);
   assign rdIrqMask = (rdSelAddr == svd_pkg::IRQ_MASK_OFFS);
   assign rdMonStat = (rdSelAddr == svd_pkg::MON_STAT_OFFS);

   always_comb
   begin
      detectView                        = 8'h00;
      detectView[svd_pkg::ENABLE_BIT]   = enable_q;
      detectView[svd_pkg::LOW_BIT]      = lowFlag_q;
      detectView[svd_pkg::HIGH_BIT]     = highFlag_q;
      irqStatView                       = 8'h00;
      irqStatView[svd_pkg::ALARM_BIT]   = alarmLatch_q;
      irqMaskView                       = 8'h00;
      irqMaskView[svd_pkg::ALARM_BIT]   = alarmMask_q;
      monStatView                       = 8'h00;
      monStatView[svd_pkg::VALID_BIT]   = (mon_q == svd_pkg::MON_ACTIVE);
   end

   assign readByte = rdDetect  ? detectView  :
                     rdIrqStat ? irqStatView :
                     rdIrqMask ? irqMaskView :
                     rdMonStat ? monStatView : 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Read data and wait state

   always_comb
   begin
      hrdata_d = hrdata_q;
      if (rdStall_q)
      begin
         hrdata_d = {24'h000000, readByte};
      end
      else if (readAccept && !readHazard)
      begin
         hrdata_d = {24'h000000, readByte};
      end
      else if (accept)
      begin
         hrdata_d = 32'h00000000;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         wrPend_q    <= 1'b0;
         wrAddr_q    <= 8'h00;
         rdStall_q   <= 1'b0;
         rdAddr_q    <= 8'h00;
         hreadyout_q <= 1'b1;
         hrdata_q    <= 32'h00000000;
      end
      else
      begin
         wrPend_q    <= writeAccept;
         wrAddr_q    <= writeAccept ? haddr[7:0] : wrAddr_q;
         rdStall_q   <= readHazard;
         rdAddr_q    <= readHazard ? haddr[7:0] : rdAddr_q;
         hreadyout_q <= !readHazard;
         hrdata_q    <= hrdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Enable and mask registers

   always_comb
   begin
      enable_d    = enable_q;
      alarmMask_d = alarmMask_q;
      if (wrDetect)
      begin
         enable_d = hwdata[svd_pkg::ENABLE_BIT];
      end
      if (wrIrqMask)
      begin
         alarmMask_d = hwdata[svd_pkg::ALARM_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Monitor sequencing and settle timer

   always_comb
   begin
      mon_d       = mon_q;
      settleCnt_d = settleCnt_q;
      case (mon_q)
         svd_pkg::MON_OFF:
         begin
            settleCnt_d = '0;
            if (enable_q)
            begin
               mon_d = svd_pkg::MON_SETTLE;
            end
         end
         svd_pkg::MON_SETTLE:
         begin
            if (!enable_q)
            begin
               mon_d = svd_pkg::MON_OFF;
            end
            else if (settleCnt_q == SETTLE_LAST)
            begin
               mon_d = svd_pkg::MON_ACTIVE;
            end
            else
            begin
               settleCnt_d = settleCnt_q + CNT_W'(1);
            end
         end
         svd_pkg::MON_ACTIVE:
         begin
            if (!enable_q)
            begin
               mon_d = svd_pkg::MON_OFF;
            end
         end
         default:
         begin
            mon_d = svd_pkg::MON_OFF;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Alarm latch, set wins over clear

   logic alarmSet;
   logic alarmClr;

   assign alarmSet = (mon_q == svd_pkg::MON_ACTIVE) && lowFlag_q;
   assign alarmClr = wrIrqStat && hwdata[svd_pkg::ALARM_BIT];

   always_comb
   begin
      alarmLatch_d = alarmLatch_q;
      if (alarmSet)
      begin
         alarmLatch_d = 1'b1;
      end
      else if (alarmClr)
      begin
         alarmLatch_d = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State registers

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         enable_q     <= svd_pkg::ENABLE_RST;
         alarmMask_q  <= svd_pkg::IRQ_MASK_RST[svd_pkg::ALARM_BIT];
         alarmLatch_q <= svd_pkg::IRQ_STAT_RST[svd_pkg::ALARM_BIT];
         mon_q        <= svd_pkg::MON_OFF;
         settleCnt_q  <= '0;
      end
      else
      begin
         enable_q     <= enable_d;
         alarmMask_q  <= alarmMask_d;
         alarmLatch_q <= alarmLatch_d;
         mon_q        <= mon_d;
         settleCnt_q  <= settleCnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Level flags and request lines

   logic monitorNext;

   // Flags follow the enable as written, so a read never sees a stale flag
   assign monitorNext = enable_d;

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         highFlag_q <= svd_pkg::FLAG_RST;
         lowFlag_q  <= svd_pkg::FLAG_RST;
         alarmReq_q <= 1'b0;
         irq_q      <= 1'b0;
      end
      else
      begin
         highFlag_q <= monitorNext && highSync;
         lowFlag_q  <= monitorNext && lowSync;
         alarmReq_q <= monitorNext && lowFlag_q;
         irq_q      <= alarmLatch_d && alarmMask_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign hreadyout           = hreadyout_q;
   assign hresp               = 1'b0;
   assign hrdata              = hrdata_q;
   assign supplyMonitorEnable = enable_q;
   assign supplyAlarmRequest  = alarmReq_q;
   assign irq                 = irq_q;

endmodule

// ===== testbench/svd_analog_model.sv
// Comparator pair model of the supply monitor
// Assumes the bench sets supplyLevel: 0 low, 1 normal, 2 high
`timescale 1ns/10ps
module svd_analog_model
(
   input  wire logic [1:0] supplyLevel,
   output logic            aboveUpperThreshold,
   output logic            belowLowerThreshold
);
   // Comparators track the supply whether or not monitoring is enabled
   assign aboveUpperThreshold = (supplyLevel == 2'h2);
   assign belowLowerThreshold = (supplyLevel == 2'h0);
endmodule

// ===== testbench/svd_checker.sv
// Port checker for the supply voltage detect block
// Assumes one clock domain and synchronous active-high reset
`timescale 1ns/10ps
module svd_checker
#(
   parameter int SETTLE_CYCLES = svd_pkg::SETTLE_CYCLES
)
(
   input wire logic        sys_clk,
   input wire logic        srst,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        belowLowerThreshold,
   input wire logic        supplyMonitorEnable,
   input wire logic        supplyAlarmRequest,
   input wire logic        irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   logic [31:0] enCount_q;
   always_ff @(posedge sys_clk)
   begin
      if (srst || !supplyMonitorEnable)
         enCount_q <= 32'h0;
      else if (enCount_q < SETTLE_CYCLES + 8)
         enCount_q <= enCount_q + 32'h1;
   end
   sequence lowHeld;
      (supplyMonitorEnable && belowLowerThreshold) [*6];
   endsequence
   chk_reset_clear: assert property ($past(srst) |-> !supplyMonitorEnable && !irq)
      else $error("outputs not cleared by reset");
   chk_low_request: assert property (lowHeld |-> supplyAlarmRequest)
      else $error("low supply gave no request");
   chk_no_low: assert property (!belowLowerThreshold [*6] |-> !supplyAlarmRequest)
      else $error("request without low supply");
   chk_off_quiet: assert property (!supplyMonitorEnable [*2] |-> !supplyAlarmRequest)
      else $error("request while disabled");
   chk_irq_settle: assert property ($rose(irq) |-> enCount_q >= SETTLE_CYCLES)
      else $error("interrupt before settling");
   chk_irq_cause: assert property ($rose(irq) |->
      supplyAlarmRequest || $past(supplyAlarmRequest))
      else $error("interrupt without low supply");
   chk_wait_one: assert property (!hreadyout |=> hreadyout)
      else $error("wait state too long");
   chk_resp_okay: assert property (hresp == 1'b0 && hrdata[31:8] == 24'h0)
      else $error("bad response or upper data");
endmodule
bind svd_top svd_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk
(
   .sys_clk(sys_clk), .srst(srst), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .belowLowerThreshold(belowLowerThreshold), .supplyMonitorEnable(supplyMonitorEnable),
   .supplyAlarmRequest(supplyAlarmRequest), .irq(irq)
);

// ===== testbench/test_supply_voltage_detect_flags.sv
// Self-checking bench for the supply voltage detect block
// Assumes an AHB-Lite master model and the comparator model
`timescale 1ns/10ps
module test_supply_voltage_detect_flags;
   localparam int SC = 8;
   logic sys_clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic [1:0]  htrans = 2'h0, supplyLevel = 2'h1;
   logic hready, hresp, above, below, supplyMonitorEnable, supplyAlarmRequest, irq;
   int n_errors = 0, num_checks = 0;
   svd_top #(.SETTLE_CYCLES(SC)) dut
   (
      .sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
      .hresp(hresp), .hrdata(hrdata), .aboveUpperThreshold(above),
      .belowLowerThreshold(below), .supplyMonitorEnable(supplyMonitorEnable),
      .supplyAlarmRequest(supplyAlarmRequest), .irq(irq)
   );
   svd_analog_model partner
   (
      .supplyLevel(supplyLevel),
      .aboveUpperThreshold(above), .belowLowerThreshold(below)
   );
   initial forever #2 sys_clk = ~sys_clk;
   ////////////////////////////////////////////////////////////////////////
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
      do @(posedge sys_clk); while (hready !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      do @(posedge sys_clk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      check(q, exp);
   endtask
   task automatic pin(input logic got, input logic exp);
      check({31'h0, got}, {31'h0, exp});
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd(svd_pkg::DETECT_OFFS, 32'h0);
      rd(svd_pkg::IRQ_STAT_OFFS, 32'h0);
      rd(svd_pkg::IRQ_MASK_OFFS, 32'h0);
      rd(8'h20, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_disabled;
      supplyLevel <= 2'h0;
      xfer(1'b1, svd_pkg::DETECT_OFFS, 32'hF8);
      repeat (6) @(posedge sys_clk);
      rd(svd_pkg::DETECT_OFFS, 32'h0);
      pin(supplyAlarmRequest, 1'b0);
      $display("test disabled done");
   endtask
   task automatic t_settle;
      xfer(1'b1, svd_pkg::IRQ_MASK_OFFS, 32'h20);
      xfer(1'b1, svd_pkg::DETECT_OFFS, 32'h1);
      rd(svd_pkg::MON_STAT_OFFS, 32'h0);
      rd(svd_pkg::IRQ_STAT_OFFS, 32'h0);
      repeat (SC + 12) @(posedge sys_clk);
      rd(svd_pkg::MON_STAT_OFFS, 32'h1);
      rd(svd_pkg::DETECT_OFFS, 32'h3);
      pin(supplyAlarmRequest, 1'b1);
      rd(svd_pkg::IRQ_STAT_OFFS, 32'h20);
      pin(irq, 1'b1);
      $display("test settle done");
   endtask
   task automatic t_mask_clear;
      xfer(1'b1, svd_pkg::IRQ_MASK_OFFS, 32'h0);
      rd(svd_pkg::IRQ_STAT_OFFS, 32'h20);
      pin(irq, 1'b0);
      supplyLevel <= 2'h2;
      repeat (6) @(posedge sys_clk);
      rd(svd_pkg::DETECT_OFFS, 32'h5);
      pin(supplyAlarmRequest, 1'b0);
      rd(svd_pkg::IRQ_STAT_OFFS, 32'h20);
      xfer(1'b1, svd_pkg::IRQ_STAT_OFFS, 32'h20);
      rd(svd_pkg::IRQ_STAT_OFFS, 32'h0);
      $display("test mask and clear done");
   endtask
   task automatic t_disable;
      xfer(1'b1, svd_pkg::DETECT_OFFS, 32'h0);
      rd(svd_pkg::DETECT_OFFS, 32'h0);
      pin(supplyMonitorEnable, 1'b0);
      rd(svd_pkg::MON_STAT_OFFS, 32'h0);
      $display("test disable done");
   endtask
   task automatic t_rst_mid;
      supplyLevel <= 2'h0;
      xfer(1'b1, svd_pkg::DETECT_OFFS, 32'h1);
      repeat (SC + 12) @(posedge sys_clk);
      rd(svd_pkg::IRQ_STAT_OFFS, 32'h20);
      srst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      rd(svd_pkg::DETECT_OFFS, 32'h0);
      rd(svd_pkg::IRQ_STAT_OFFS, 32'h0);
      rd(svd_pkg::MON_STAT_OFFS, 32'h0);
      pin(supplyAlarmRequest, 1'b0);
      $display("test mid-run reset done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      #20000;
      n_errors++;
      report_and_stop();
   end
   initial
   begin
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      t_reset();
      t_disabled();
      t_settle();
      t_mask_clear();
      t_disable();
      t_rst_mid();
      report_and_stop();
   end
endmodule
